//--- core/ama_pkg.sv
// package for the auto-mode ack/cca control block
// assumes an apb slave with 32-bit words, one register per word
package ama_pkg;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_THRESH = 12'h004;
   localparam logic [11:0] OFF_PEND = 12'h008;
   localparam logic [11:0] OFF_DLY_LO = 12'h00c;
   localparam logic [11:0] OFF_DLY_HI = 12'h010;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
   // control field positions
   localparam int B_SENT = 7;
   localparam int B_FCS = 6;
   localparam int B_RATE = 5;
   localparam int B_SRC = 4;
   localparam int B_AUTO_ACK_ENABLE = 3;
   localparam int B_BUSY = 2;
   localparam int B_CCA = 1;
   localparam int B_T2R = 0;
   localparam logic [7:0] CTRL_RW_MASK = 8'h7b;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic channel_clear_code = 1'b0;
   localparam logic channel_busy_code = 1'b1;
   localparam int NUM_UNITS = 4;
   localparam int DLY_W = 11;
   // interrupt status bits
   localparam int I_ACK = 0;
   localparam int I_CCA = 1;
   localparam int I_T2R = 2;
   localparam int IRQ_W = 3;
   // one microsecond in clock cycles at 20 mhz
   localparam int CLK_MHZ = 20;
   localparam int US_NS = 1000;
   localparam int CLK_NS = 50;
   localparam int CYC_PER_US = US_NS / CLK_NS;
   typedef enum logic [1:0] {
      AMA_IDLE = 2'b00,
      AMA_WAIT = 2'b01,
      AMA_SEND = 2'b11,
      AMA_CCA = 2'b10
   } ama_state_t;
   // ack request handed to the transmitter
   typedef struct packed {
      logic fromBuffer;
      logic fcsType;
      logic rateFromRx;
      logic pending;
   } ama_ack_req_t;
endpackage : ama_pkg

//--- core/ama_ctrl.sv
// auto-mode ack / cca-with-transmit / transmit-then-receive control
// assumes baseband events are one-cycle pulses on sys_clk; registers over apb
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module ama_ctrl #(
   parameter int NUM_UNITS = ama_pkg::NUM_UNITS
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic filterEnable,
   input wire logic configured_fcs_type,
   input wire logic rx_frame_end_event,
   input wire logic rxFrameFcsType,
   input wire logic rxFrameAccepted,
   input wire logic [NUM_UNITS-1:0] unitMatch,
   input wire logic [NUM_UNITS-1:0] unitDataRequest,
   input wire logic edDone,
   input wire logic signed [7:0] edValue,
   input wire logic txDone,
   output logic edStart,
   output logic ackStart,
   output ama_pkg::ama_ack_req_t ackReq,
   output logic txStart,
   output logic ccaDone,
   output logic rxEnter,
   output logic irq
);
   logic [7:0] ctrl_q;
   logic [7:0] thresh_q;
   logic [7:0] pend_q;
   logic [7:0] dlyLo_q;
   logic [2:0] dlyHi_q;
   logic [ama_pkg::IRQ_W-1:0] stat_q;
   logic [ama_pkg::IRQ_W-1:0] mask_q;
   logic [31:0] prdata_q;
   ama_pkg::ama_state_t state_q;
   ama_pkg::ama_state_t state_d;
   logic [ama_pkg::DLY_W-1:0] usCnt_q;
   logic [4:0] preCnt_q;
   logic [NUM_UNITS-1:0] sawReq_q;
   logic ccaRun_q;
   ama_pkg::ama_ack_req_t ackReq_q;
   logic edStart_q;
   logic ackStart_q;
   logic txStart_q;
   logic ccaDone_q;
   logic rxEnter_q;

   // bus decode
   wire logic wrEn = psel & penable & pwrite;
   wire logic rdSetup = psel & ~penable & ~pwrite;
   wire logic selCtrl = paddr == ama_pkg::OFF_CTRL;
   wire logic selThr = paddr == ama_pkg::OFF_THRESH;
   wire logic selPend = paddr == ama_pkg::OFF_PEND;
   wire logic selLo = paddr == ama_pkg::OFF_DLY_LO;
   wire logic selHi = paddr == ama_pkg::OFF_DLY_HI;
   wire logic selStat = paddr == ama_pkg::OFF_IRQ_STAT;
   wire logic selMask = paddr == ama_pkg::OFF_IRQ_MASK;
   wire logic mapped = selCtrl | selThr | selPend | selLo | selHi | selStat | selMask;
   wire logic [7:0] wb = pwdata[7:0];
   wire logic wrCtrl = wrEn & selCtrl;
   wire logic wrThr = wrEn & selThr;
   wire logic wrPend = wrEn & selPend;
   wire logic wrLo = wrEn & selLo;
   wire logic wrHi = wrEn & selHi;
   wire logic wrStat = wrEn & selStat;
   wire logic wrMask = wrEn & selMask;
   wire logic [ama_pkg::IRQ_W-1:0] statClr =
      wrStat ? wb[ama_pkg::IRQ_W-1:0] : {ama_pkg::IRQ_W{1'b0}};

   wire logic autoAckOn = ctrl_q[ama_pkg::B_AUTO_ACK_ENABLE] & filterEnable;
   wire logic ccaTxOn = ctrl_q[ama_pkg::B_CCA];
   wire logic busyNow = edValue > $signed(thresh_q);
   wire logic ccaEnd = ccaRun_q & edDone;
   wire logic ackWanted = autoAckOn & rx_frame_end_event & rxFrameAccepted;
   wire logic [ama_pkg::DLY_W-1:0] ackDelay = {dlyHi_q, dlyLo_q};
   wire logic usTick = preCnt_q == 5'(ama_pkg::CYC_PER_US - 1);
   wire logic waitOver = usCnt_q == '0;
   wire logic [NUM_UNITS-1:0] pendHit = pend_q[NUM_UNITS-1:0] & sawReq_q;
   wire logic ackFcs = ctrl_q[ama_pkg::B_FCS] ? rxFrameFcsType : configured_fcs_type;
   wire logic [ama_pkg::IRQ_W-1:0] evt = {txDone & ctrl_q[ama_pkg::B_T2R], ccaEnd,
      ackWanted};
   wire logic [7:0] ctrlRead = ctrl_q;
   wire logic [7:0] ctrlWr = (ctrl_q & ~ama_pkg::CTRL_RW_MASK) | (wb & ama_pkg::CTRL_RW_MASK);
   wire logic ackDue = state_q == ama_pkg::AMA_WAIT & waitOver;
   wire logic edKick = ccaTxOn & ~ccaRun_q & ~edStart_q & txDone;
   wire logic [31:0] rdMux =
      selCtrl ? {24'h000000, ctrlRead} :
      selThr ? {24'h000000, thresh_q} :
      selPend ? {24'h000000, pend_q} :
      selLo ? {24'h000000, dlyLo_q} :
      selHi ? {29'h00000000, dlyHi_q} :
      selStat ? {29'h00000000, stat_q} :
      selMask ? {29'h00000000, mask_q} : 32'h00000000;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_q;
   assign irq = |(stat_q & mask_q);
   assign ackReq = ackReq_q;
   assign edStart = edStart_q;
   assign ackStart = ackStart_q;
   assign txStart = txStart_q;
   assign ccaDone = ccaDone_q;
   assign rxEnter = rxEnter_q;

   // per-unit data request memory, loaded from unitDataRequest whenever that unit matches
   genvar u;
   generate
      for (u = 0; u < NUM_UNITS; u++) begin : g_unit
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               sawReq_q[u] <= 1'b0;
            end else if (unitMatch[u]) begin
               sawReq_q[u] <= unitDataRequest[u];
            end
         end
      end
   endgenerate

   // control byte: software bits from the bus, result bits from hardware
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= ama_pkg::RST_BYTE;
      end else begin
         if (wrCtrl) begin
            ctrl_q <= ctrlWr;
         end
         if (ccaEnd) begin
            ctrl_q[ama_pkg::B_BUSY] <= busyNow;
         end
         if (autoAckOn & rx_frame_end_event) begin
            ctrl_q[ama_pkg::B_SENT] <= ackWanted;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         thresh_q <= ama_pkg::RST_BYTE;
      end else if (wrThr) begin
         thresh_q <= wb;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_q <= ama_pkg::RST_BYTE;
      end else if (wrPend) begin
         pend_q <= {4'h0, wb[3:0]};
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dlyLo_q <= ama_pkg::RST_BYTE;
      end else if (wrLo) begin
         dlyLo_q <= wb;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dlyHi_q <= 3'h0;
      end else if (wrHi) begin
         dlyHi_q <= wb[2:0];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_q <= '0;
      end else if (wrMask) begin
         mask_q <= wb[ama_pkg::IRQ_W-1:0];
      end
   end

   // a hardware event wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~statClr) | evt;
      end
   end

   // read data taken in the setup phase so it stands through the access phase
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_q <= 32'h00000000;
      end else if (rdSetup) begin
         prdata_q <= rdMux;
      end
   end

   // ack delay sequence; the AMA_CCA state is never entered
   always_comb begin
      state_d = state_q;
      case (state_q)
         ama_pkg::AMA_IDLE: begin
            if (ackWanted) state_d = ama_pkg::AMA_WAIT;
         end
         ama_pkg::AMA_WAIT: begin
            if (waitOver) state_d = ama_pkg::AMA_SEND;
         end
         ama_pkg::AMA_SEND: state_d = ama_pkg::AMA_IDLE;
         ama_pkg::AMA_CCA: state_d = ama_pkg::AMA_IDLE;
         default: state_d = ama_pkg::AMA_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ama_pkg::AMA_IDLE;
         usCnt_q <= '0;
         preCnt_q <= 5'h00;
      end else begin
         state_q <= state_d;
         if (ackWanted & state_q == ama_pkg::AMA_IDLE) begin
            usCnt_q <= ackDelay;
            preCnt_q <= 5'h00;
         end else if (state_q == ama_pkg::AMA_WAIT & ~waitOver) begin
            preCnt_q <= usTick ? 5'h00 : preCnt_q + 5'h01;
            if (usTick) usCnt_q <= usCnt_q - 11'h001;
         end
      end
   end

   // ack start pulse and the request captured at the frame end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ackStart_q <= 1'b0;
      end else begin
         ackStart_q <= ackDue;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ackReq_q <= '0;
      end else if (ackWanted) begin
         ackReq_q.fromBuffer <= ctrl_q[ama_pkg::B_SRC];
         ackReq_q.fcsType <= ackFcs;
         ackReq_q.rateFromRx <= ctrl_q[ama_pkg::B_RATE];
         ackReq_q.pending <= ~ctrl_q[ama_pkg::B_SRC] & |pendHit;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         edStart_q <= 1'b0;
      end else begin
         edStart_q <= edKick;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ccaRun_q <= 1'b0;
      end else if (edStart_q) begin
         ccaRun_q <= 1'b1;
      end else if (ccaEnd | ~ccaTxOn) begin
         ccaRun_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txStart_q <= 1'b0;
      end else begin
         txStart_q <= ccaEnd & (busyNow == ama_pkg::channel_clear_code);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ccaDone_q <= 1'b0;
      end else begin
         ccaDone_q <= ccaEnd;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxEnter_q <= 1'b0;
      end else begin
         rxEnter_q <= txDone & ctrl_q[ama_pkg::B_T2R];
      end
   end
endmodule : ama_ctrl

//--- verification/ama_ctrl_asserts.sv
// port checker for the auto-mode control block
// assumes it is bound to ama_ctrl and sees its ports only
`timescale 1ns/100ps
module ama_ctrl_asserts (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_frame_end_event,
   input wire logic txDone,
   input wire logic edDone,
   input wire logic edStart,
   input wire logic txStart,
   input wire logic ccaDone,
   input wire logic rxEnter,
   input wire logic ackStart
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_unmapped: assert property (psel && penable
      && (paddr > ama_pkg::OFF_IRQ_MASK || paddr[1:0] != 2'b00) |-> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (psel && penable
      && paddr <= ama_pkg::OFF_IRQ_MASK && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("error on mapped access");
   a_tx_with_done: assert property (txStart |-> ccaDone)
      else $error("transmit start outside cca completion");
   a_cca_start: assert property (edStart |-> $past(txDone))
      else $error("energy start without transmit end");
   a_cca_done: assert property (ccaDone |-> $past(edDone))
      else $error("cca done without energy result");
   a_tx_clear: assert property (txStart |-> $past(edDone))
      else $error("transmit start without cca");
   a_rx_switch: assert property (rxEnter |-> $past(txDone))
      else $error("receive switch without transmit end");
   a_ack_pulse: assert property (ackStart |=> !ackStart)
      else $error("ack start longer than one cycle");
   a_ack_early: assert property (rx_frame_end_event |-> ##1 !ackStart)
      else $error("ack start too early");
endmodule : ama_ctrl_asserts
bind ama_ctrl ama_ctrl_asserts chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .rx_frame_end_event(rx_frame_end_event), .txDone(txDone), .edDone(edDone),
   .edStart(edStart), .txStart(txStart), .ccaDone(ccaDone), .rxEnter(rxEnter),
   .ackStart(ackStart));

//--- verification/ama_radio_model.sv
// far-side radio: answers energy and transmit requests after a fixed latency
// assumes one-cycle request pulses; energy is garbage outside its done pulse
`timescale 1ns/100ps
module ama_radio_model #(
   parameter int LAT = 10
) (
   input wire logic sys_clk,
   input wire logic edStart,
   input wire logic txStart,
   input wire logic ackStart,
   input wire logic txKick,
   input wire logic signed [7:0] energy,
   output logic edDone,
   output logic txDone,
   output logic signed [7:0] edValue
);
   logic [15:0] edSh_q = '0;
   logic [15:0] txSh_q = '0;
   always_ff @(posedge sys_clk) begin
      edSh_q <= {edSh_q[14:0], edStart};
      txSh_q <= {txSh_q[14:0], txStart | ackStart | txKick};
   end
   assign edDone = edSh_q[LAT];
   assign txDone = txSh_q[LAT];
   assign edValue = edDone ? energy : ~energy;
endmodule : ama_radio_model

//--- verification/testbench.sv
// self-checking bench for the auto-mode control block
// assumes the control block, its checker and the radio model
`timescale 1ns/100ps
module testbench;
   logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err, sent;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, edStart, ackStart, txStart, ccaDone, rxEnter, irq, edDone, txDone;
   logic filterEnable = 0, configured_fcs_type = 0, rx_frame_end_event = 0;
   logic rxFrameFcsType = 0, rxFrameAccepted = 1, txKick = 0;
   logic [3:0] unitMatch = '0, unitDataRequest = '0;
   logic signed [7:0] edValue, energy = '0;
   ama_pkg::ama_ack_req_t ackReq;
   int bad_count = 0, cmp_count = 0, n;
   ama_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .filterEnable(filterEnable),
      .configured_fcs_type(configured_fcs_type), .rx_frame_end_event(rx_frame_end_event),
      .rxFrameFcsType(rxFrameFcsType), .rxFrameAccepted(rxFrameAccepted),
      .unitMatch(unitMatch), .unitDataRequest(unitDataRequest), .edDone(edDone),
      .edValue(edValue), .txDone(txDone), .edStart(edStart), .ackStart(ackStart),
      .ackReq(ackReq), .txStart(txStart), .ccaDone(ccaDone), .rxEnter(rxEnter), .irq(irq));
   ama_radio_model partner (.sys_clk(sys_clk), .edStart(edStart), .txStart(txStart),
      .ackStart(ackStart), .txKick(txKick), .energy(energy), .edDone(edDone),
      .txDone(txDone), .edValue(edValue));
   initial forever #25 sys_clk = ~sys_clk;
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task pulse_tx;
      txKick <= 1;
      @(posedge sys_clk);
      txKick <= 0;
   endtask : pulse_tx
   task t_regs;
      for (int i = 0; i < 5; i++) begin
         apb(0, 12'(i * 4), 0);
         chk("reset value", rd, 32'(ama_pkg::RST_BYTE));
      end
      apb(1, ama_pkg::OFF_CTRL, 32'hff);
      apb(0, ama_pkg::OFF_CTRL, 0);
      chk("control access", rd, 32'h7b);
      apb(0, 12'h01c, 0);
      chk("unmapped error", 32'(err), 1);
      $display("test regs done");
   endtask : t_regs
   task t_ack(input logic [7:0] c, input logic [10:0] d, input logic f, input logic [3:0] r,
      input int e, input logic a);
      apb(1, ama_pkg::OFF_DLY_LO, 32'(d[7:0]));
      apb(1, ama_pkg::OFF_DLY_HI, 32'(d[10:8]));
      apb(1, ama_pkg::OFF_CTRL, 32'(c));
      apb(0, ama_pkg::OFF_CTRL, 0);
      sent = rd[ama_pkg::B_SENT];
      rxFrameFcsType <= f;
      rx_frame_end_event <= 1;
      @(posedge sys_clk);
      rx_frame_end_event <= 0;
      n = 1;
      #1;
      while (ackStart !== 1'b1 && n < e + 2) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk("ack start cycle", 32'(n), 32'(a ? e : e + 2));
      chk("ack request", 32'(ackReq), 32'(r));
      apb(0, ama_pkg::OFF_CTRL, 0);
      chk("ack sent flag", 32'(rd[7]), 32'(a ? 1'b1 : sent));
      $display("test ack done");
   endtask : t_ack
   task t_cca(input logic signed [7:0] e, input logic busy);
      energy <= e;
      apb(1, ama_pkg::OFF_CTRL, 32'h02);
      pulse_tx;
      n = 0;
      sent = 0;
      do begin
         @(posedge sys_clk);
         #1 sent |= txStart;
         n++;
      end while (ccaDone !== 1'b1 && n < 60);
      @(posedge sys_clk);
      #1 sent |= txStart;
      apb(0, ama_pkg::OFF_CTRL, 0);
      apb(1, ama_pkg::OFF_CTRL, 0);
      repeat (20) @(posedge sys_clk);
      chk("busy result", 32'(rd[2]), 32'(busy));
      chk("cca transmit", 32'(sent), 32'(!busy));
      $display("test cca done");
   endtask : t_cca
   task t_t2r;
      apb(1, ama_pkg::OFF_IRQ_STAT, 32'h07);
      apb(1, ama_pkg::OFF_IRQ_MASK, 32'h04);
      apb(1, ama_pkg::OFF_CTRL, 32'h01);
      pulse_tx;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
      end while (rxEnter !== 1'b1 && ++n < 30);
      chk("receive switch", 32'(rxEnter), 1);
      apb(0, ama_pkg::OFF_IRQ_STAT, 0);
      chk("irq status", rd, 32'h04);
      chk("irq level", 32'(irq), 1);
      apb(1, ama_pkg::OFF_IRQ_MASK, 0);
      #1 chk("irq masked", 32'(irq), 0);
      apb(1, ama_pkg::OFF_IRQ_MASK, 32'h04);
      apb(1, ama_pkg::OFF_IRQ_STAT, 32'h04);
      #1 chk("irq cleared", 32'(irq), 0);
      $display("test t2r done");
   endtask : t_t2r
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 0;
      t_regs;
      filterEnable <= 1;
      unitDataRequest <= 4'h4;
      unitMatch <= 4'h4;
      @(posedge sys_clk);
      unitMatch <= 4'h0;
      apb(1, ama_pkg::OFF_PEND, 32'h04);
      t_ack(8'h68, 11'h001, 1, 4'h7, 22, 1);
      configured_fcs_type <= 1;
      t_ack(8'h18, 11'h000, 0, 4'hc, 2, 1);
      t_ack(8'h08, 11'h7ff, 0, 4'h5, 40942, 1);
      filterEnable <= 0;
      t_ack(8'h08, 11'h000, 1, 4'h5, 2, 0);
      apb(1, ama_pkg::OFF_THRESH, 32'hfb);
      t_cca(-8'sd4, 1);
      t_cca(-8'sd5, 0);
      t_cca(8'sd127, 1);
      t_t2r;
      results;
   end
   initial begin
      repeat (50000) @(posedge sys_clk);
      bad_count++;
      results;
   end
endmodule : testbench
